// [lat_regs.svh]
// Purpose: Register map and field positions of the trigger/capture block
// Assumes: 32-bit plain register port, byte offsets
// Notes: Definitions only
`ifndef LAT_REGS_SVH
`define LAT_REGS_SVH
`define LAT_OFS_CTRL    8'h00
`define LAT_OFS_EQN     8'h04
`define LAT_OFS_POS     8'h08
`define LAT_OFS_BURST   8'h0c
`define LAT_OFS_STATUS  8'h10
`define LAT_OFS_RDIDX   8'h14
`define LAT_OFS_RDDATA  8'h18
`define LAT_CTRL_ARM    0
`define LAT_CTRL_STOP   1
`define LAT_CTRL_MACRO  2
`define LAT_CTRL_PERTRG 3
`define LAT_CTRL_EXTEN  4
`define LAT_CTRL_OR     5
`define LAT_EQN_M0_LSB  0
`define LAT_EQN_M1_LSB  2
`define LAT_EQN_EXT_LSB 4
`define LAT_SEL_UNUSED  2'h0
`define LAT_SEL_TRUE    2'h1
`define LAT_SEL_INV     2'h2
`define LAT_STAT_CNT_LSB 16
`define LAT_CFG_RESET   11'h000
`endif

// [lat_pkg.sv]
// Purpose: Types shared by the trigger/capture block
// Assumes: Constants come from lat_regs.svh
// Notes: None
package lat_pkg;
    typedef enum logic [2:0] {
        LAT_ST_IDLE  = 3'b000,
        LAT_ST_ARMED = 3'b001,
        LAT_ST_POST  = 3'b010,
        LAT_ST_FULL  = 3'b011,
        LAT_ST_STOP  = 3'b100
    } lat_state_e;
    typedef struct packed {
        logic       macro;
        logic       per_trig;
        logic       ext_en;
        logic       op_or;
        logic [1:0] sel_m0;
        logic [1:0] sel_m1;
        logic [1:0] sel_ext;
        logic       spare;
    } lat_cfg_s;
endpackage

// [lat_trigger_capture.sv]
// Purpose: Trigger combiner and capture sequencer of a logic analyzer core
// Assumes: Match unit results on mclk_i; external trigger asynchronous
// Notes: Sample index zero is the trigger sample
// Contract
// RULE1: Combine match units and external input
// RULE2: Boolean operator selectable AND or OR
// RULE3: Each operand true or inverted
// RULE4: Unused operand excluded from equation
// RULE5: If-then only with extended match units
// RULE6: Macro fires first then second operand
// RULE7: Host uses boolean when macro unused
// RULE8: Single capture keeps pre and post samples
// RULE9: Trigger position zero to depth minus one
// RULE10: Keep P before, depth minus P after
// RULE11: Per-trigger bursts until buffer full
// RULE12: Burst length programmable one to sixteen
// RULE13: Stop mid-burst when buffer fills
// RULE14: Drive overall trigger to hub output
// RULE15: Hub ORs all cores trigger outputs
// RULE16: Output zero when enable cleared
// RULE17: Sample zero aligned to first trigger
// RULE18: Report armed, count, full or stopped
// RULE19: Evaluate each edge, clear stage on arm
// RULE20: Full ignores triggers until re-armed
`timescale 1ns/1ps
`include "lat_regs.svh"

module lat_trigger_capture #(
    parameter int DEPTH    = 2048,
    parameter int WIDTH    = 16,
    parameter bit EXTENDED = 1'b1
) (
    input  wire logic              mclk_i,
    input  wire logic              reset_i,
    input  wire logic [7:0]        addr_i,
    input  wire logic [31:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [31:0]       rdata_o,
    input  wire logic              m0_i,
    input  wire logic              m1_i,
    input  wire logic              ext_trig_i,
    input  wire logic [WIDTH-1:0]  sample_i,
    output logic                   trig_out_o
);
    import lat_pkg::*;

    localparam int AD = $clog2(DEPTH);
    localparam logic [AD:0] DEPTH_C = (AD + 1)'(DEPTH);

    function automatic logic term_val(input logic [1:0] sel, input logic v);
        term_val = (sel == `LAT_SEL_INV) ? ~v : v;
    endfunction

    function automatic logic term_used(input logic [1:0] sel);
        term_used = (sel != `LAT_SEL_UNUSED);
    endfunction

    lat_state_e         st_reg;
    lat_state_e         st_next;
    lat_cfg_s           cfg_reg;
    logic [AD-1:0]      pos_reg;
    logic [3:0]         burst_reg;
    logic [AD-1:0]      rdidx_reg;
    logic [31:0]        rdata_reg;
    logic               trig_out_reg;
    logic               ext_s1_reg;
    logic               ext_s2_reg;
    logic               stage_reg;
    logic [AD-1:0]      wptr_reg;
    logic [AD-1:0]      taddr_reg;
    logic [AD-1:0]      pre_reg;
    logic [AD:0]        left_reg;
    logic [AD:0]        cnt_reg;
    logic [3:0]         bcnt_reg;
    logic [WIDTH-1:0]   mem [DEPTH];

    // Register decode
    wire wr_ctrl  = wr_i && (addr_i == `LAT_OFS_CTRL);
    wire wr_eqn   = wr_i && (addr_i == `LAT_OFS_EQN);
    wire wr_pos   = wr_i && (addr_i == `LAT_OFS_POS);
    wire wr_burst = wr_i && (addr_i == `LAT_OFS_BURST);
    wire wr_rdidx = wr_i && (addr_i == `LAT_OFS_RDIDX);
    wire arm      = wr_ctrl && wdata_i[`LAT_CTRL_ARM];
    wire stop     = wr_ctrl && wdata_i[`LAT_CTRL_STOP] && !arm;

    // Operand terms
    wire t_m0  = term_val(cfg_reg.sel_m0, m0_i);                    // RULE3
    wire t_m1  = term_val(cfg_reg.sel_m1, m1_i);                    // RULE3
    wire t_ext = term_val(cfg_reg.sel_ext, ext_s2_reg);             // RULE3
    wire u_m0  = term_used(cfg_reg.sel_m0);
    wire u_m1  = term_used(cfg_reg.sel_m1);
    wire u_ext = term_used(cfg_reg.sel_ext);
    wire any_u = u_m0 || u_m1 || u_ext;

    // Boolean equation, unused operands drop out
    wire and_eq = (t_m0 || !u_m0) && (t_m1 || !u_m1) && (t_ext || !u_ext);  // RULE4
    wire or_eq  = (t_m0 && u_m0) || (t_m1 && u_m1) || (t_ext && u_ext);     // RULE4
    wire bool_hit = any_u && (cfg_reg.op_or ? or_eq : and_eq);              // RULE2

    // If-then: first is match zero, second is match one with external input
    wire first_ok  = u_m0 ? t_m0 : 1'b1;
    wire sec_used  = u_m1 || u_ext;
    wire second_ok = (t_m1 || !u_m1) && (t_ext || !u_ext);
    wire macro_on  = EXTENDED && cfg_reg.macro;                     // RULE5
    wire macro_hit = (u_m0 || sec_used) && stage_reg && second_ok;  // RULE6

    wire hit = macro_on ? macro_hit : bool_hit;                     // RULE1

    // Capture sequencing
    wire ptrig    = cfg_reg.per_trig;
    wire in_arm   = (st_reg == LAT_ST_ARMED);
    wire in_post  = (st_reg == LAT_ST_POST);
    wire burst_on = (bcnt_reg != 4'h0);
    wire pre_ok   = ptrig || (pre_reg >= pos_reg);                  // RULE10
    wire fire     = hit && ((in_arm && pre_ok) ||
                            (in_post && ptrig && !burst_on));       // RULE11
    wire wr_en    = (in_arm && !ptrig) || fire ||
                    (in_post && (!ptrig || burst_on));              // RULE8
    wire counted  = wr_en && (in_post || fire);
    wire first_f  = fire && in_arm;
    wire pre_step = in_arm && !ptrig && !fire && (pre_reg < pos_reg);  // RULE10

    // Writes still owed, loaded at the first trigger
    wire [AD:0] post_len = DEPTH_C - {1'b0, pos_reg};               // RULE10
    wire [AD:0] load_len = ptrig ? DEPTH_C : post_len;              // RULE11
    wire [AD:0] left_now = first_f ? load_len : left_reg;
    wire        last     = counted && (left_now == (AD + 1)'(1));   // RULE13

    wire [AD-1:0] rd_addr = taddr_reg + rdidx_reg;                  // RULE17

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            LAT_ST_IDLE:  st_next = st_reg;
            LAT_ST_ARMED: begin
                if (last) begin
                    st_next = LAT_ST_FULL;
                end else if (fire) begin
                    st_next = LAT_ST_POST;
                end
            end
            LAT_ST_POST: begin
                if (last) begin
                    st_next = LAT_ST_FULL;                          // RULE20
                end
            end
            LAT_ST_FULL:  st_next = st_reg;                         // RULE20
            LAT_ST_STOP:  st_next = st_reg;
            default:      st_next = LAT_ST_IDLE;
        endcase
        if (stop) begin
            st_next = LAT_ST_STOP;                                  // RULE18
        end
        if (arm) begin
            st_next = LAT_ST_ARMED;
        end
    end

    // Status word
    wire [2:0]  st_code  = st_reg;
    wire [15:0] cnt_word = {{(16 - (AD + 1)){1'b0}}, cnt_reg};
    wire [31:0] status   = {cnt_word, 13'h0000, st_code};              // RULE18

    wire [31:0] rd_mux =
        (addr_i == `LAT_OFS_CTRL)   ? {21'h000000, cfg_reg} :
        (addr_i == `LAT_OFS_EQN)    ? {26'h0000000, cfg_reg.sel_ext,
                                       cfg_reg.sel_m1, cfg_reg.sel_m0} :
        (addr_i == `LAT_OFS_POS)    ? {{(32 - AD){1'b0}}, pos_reg} :
        (addr_i == `LAT_OFS_BURST)  ? {28'h0000000, burst_reg} :
        (addr_i == `LAT_OFS_STATUS) ? status :
        (addr_i == `LAT_OFS_RDIDX)  ? {{(32 - AD){1'b0}}, rdidx_reg} :
        (addr_i == `LAT_OFS_RDDATA) ? {{(32 - WIDTH){1'b0}}, mem[rd_addr]} :
        32'h00000000;

    // Configuration registers
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cfg_reg <= `LAT_CFG_RESET;
        end else if (wr_ctrl) begin
            cfg_reg.macro    <= wdata_i[`LAT_CTRL_MACRO];
            cfg_reg.per_trig <= wdata_i[`LAT_CTRL_PERTRG];
            cfg_reg.ext_en   <= wdata_i[`LAT_CTRL_EXTEN];
            cfg_reg.op_or    <= wdata_i[`LAT_CTRL_OR];
        end else if (wr_eqn) begin
            cfg_reg.sel_m0  <= wdata_i[`LAT_EQN_M0_LSB +: 2];
            cfg_reg.sel_m1  <= wdata_i[`LAT_EQN_M1_LSB +: 2];
            cfg_reg.sel_ext <= wdata_i[`LAT_EQN_EXT_LSB +: 2];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pos_reg   <= '0;
            burst_reg <= 4'h0;
            rdidx_reg <= '0;
        end else begin
            if (wr_pos) begin
                pos_reg <= wdata_i[AD-1:0];                         // RULE9
            end
            if (wr_burst) begin
                burst_reg <= wdata_i[3:0];                          // RULE12
            end
            if (wr_rdidx) begin
                rdidx_reg <= wdata_i[AD-1:0];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rdata_reg <= 32'h00000000;
        end else if (rd_i) begin
            rdata_reg <= rd_mux;
        end
    end

    // External trigger input synchroniser
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
        end else begin
            ext_s1_reg <= ext_trig_i;
            ext_s2_reg <= ext_s1_reg;
        end
    end

    // Trigger out toward hub
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            trig_out_reg <= 1'b0;
        end else begin
            trig_out_reg <= cfg_reg.ext_en && hit;                  // RULE14 RULE16
        end
    end

    // If-then first stage
    always_ff @(posedge mclk_i) begin
        if (reset_i || arm) begin
            stage_reg <= 1'b0;                                      // RULE19
        end else if (macro_on && first_ok && (in_arm || in_post)) begin
            stage_reg <= 1'b1;                                      // RULE6
        end
    end

    // Sequencer state
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_reg <= LAT_ST_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Buffer pointers and counters
    always_ff @(posedge mclk_i) begin
        if (reset_i || arm) begin
            wptr_reg  <= '0;
            taddr_reg <= '0;
            pre_reg   <= '0;
            cnt_reg   <= '0;
            bcnt_reg  <= 4'h0;
            left_reg  <= DEPTH_C;
        end else begin
            // Write pointer and saturating sample count
            if (wr_en) begin
                wptr_reg <= wptr_reg + 1'b1;
                if (cnt_reg != DEPTH_C) begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
            // Pre-trigger fill
            if (pre_step) begin
                pre_reg <= pre_reg + 1'b1;                          // RULE10
            end
            // Trigger address and writes left
            if (first_f) begin
                taddr_reg <= wptr_reg;                              // RULE17
            end
            if (counted) begin
                left_reg <= left_now - 1'b1;                        // RULE13
            end
            // Burst length per trigger
            if (fire) begin
                bcnt_reg <= burst_reg;                              // RULE12
            end else if (in_post && burst_on) begin
                bcnt_reg <= bcnt_reg - 1'b1;                        // RULE11
            end
        end
    end

    // Sample storage
    always_ff @(posedge mclk_i) begin
        if (wr_en) begin
            mem[wptr_reg] <= sample_i;                              // RULE8
        end
    end

    assign rdata_o    = rdata_reg;
    assign trig_out_o = trig_out_reg;

endmodule // lat_trigger_capture

// [lat_hub_model.sv]
// Purpose: Hub that merges analyzer trigger outputs
// Assumes: Two cores feed the hub
// Notes: Behavioural
`timescale 1ns/1ps
module lat_hub_model (
    input  wire logic trig_a_i,
    input  wire logic trig_b_i,
    output logic      hub_trig_o
);
    assign hub_trig_o = trig_a_i | trig_b_i;
endmodule // lat_hub_model

// [lat_tc_sva.sv]
// Purpose: Port checks of the trigger/capture block
// Assumes: Register map of lat_regs.svh, EXTENDED set
// Notes: Bound into lat_trigger_capture
`timescale 1ns/1ps
`include "lat_regs.svh"
module lat_tc_sva #(
    parameter int DEPTH = 2048
) (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [31:0] rdata_o,
    input  wire logic        m0_i,
    input  wire logic        m1_i,
    input  wire logic        ext_trig_i,
    input  wire logic        trig_out_o
);
    logic [1:0] s0_reg, s1_reg, s2_reg, sy_reg;
    logic       en_reg, or_reg, mac_reg, first_reg;
    wire wc = wr_i && addr_i == `LAT_OFS_CTRL;
    wire st = rd_i && addr_i == `LAT_OFS_STATUS;
    wire u0 = |s0_reg;
    wire u1 = |s1_reg;
    wire u2 = |s2_reg;
    wire t0 = (s0_reg == `LAT_SEL_INV) ? !m0_i : m0_i;
    wire t1 = (s1_reg == `LAT_SEL_INV) ? !m1_i : m1_i;
    wire t2 = (s2_reg == `LAT_SEL_INV) ? !sy_reg[1] : sy_reg[1];
    wire orv = u0 & t0 | u1 & t1 | u2 & t2;
    wire andv = (u0 | u1 | u2) & (!u0 | t0) & (!u1 | t1) & (!u2 | t2);
    wire hit = or_reg ? orv : andv;
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            {en_reg, or_reg, mac_reg, first_reg, s0_reg, s1_reg, s2_reg, sy_reg} <= '0;
        end else begin
            sy_reg <= {sy_reg[0], ext_trig_i};
            if (wc) {or_reg, en_reg, mac_reg} <= {wdata_i[5:4], wdata_i[2]};
            if (wr_i && addr_i == `LAT_OFS_EQN) {s2_reg, s1_reg, s0_reg} <= wdata_i[5:0];
            first_reg <= (wc && wdata_i[0]) ? 1'b0 : (first_reg | !u0 | t0);
        end
    end
    reset_out_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        $past(reset_i) |-> !trig_out_o && rdata_o == 32'h0)
        else $error("outputs not clear after reset");
    trig_gate_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        !$past(en_reg) |-> !trig_out_o) else $error("trigger out while disabled");
    trig_bool_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        !$past(mac_reg) |-> trig_out_o == $past(en_reg && hit))
        else $error("trigger out differs from equation");
    macro_order_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        $past(mac_reg) && trig_out_o |-> $past(first_reg))
        else $error("sequence fired without first operand");
    state_code_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        st |=> rdata_o[2:0] <= 3'h4) else $error("bad state code");
    count_sat_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        st |=> rdata_o[31:16] <= DEPTH) else $error("count beyond depth");
    unmapped_zero_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        rd_i && addr_i > 8'h18 |=> rdata_o == 32'h0) else $error("unmapped read not zero");
    rdata_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        !rd_i |=> $stable(rdata_o)) else $error("read data moved without read");
endmodule // lat_tc_sva
bind lat_trigger_capture lat_tc_sva #(.DEPTH(DEPTH)) sva_u (.mclk_i(mclk_i),
    .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .m0_i(m0_i), .m1_i(m1_i), .ext_trig_i(ext_trig_i),
    .trig_out_o(trig_out_o));

// [lat_trigger_capture_test.sv]
// Purpose: Register-level bench of the trigger/capture block
// Assumes: DEPTH of 64, counting sample data
// Notes: Sample value tells its capture cycle
`timescale 1ns/1ps
`include "lat_regs.svh"
module lat_trigger_capture_test;
    localparam int DEPTH = 64;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [7:0]  addr_i = 8'h0;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic        m0_i = 1'b0;
    logic        m1_i = 1'b0;
    logic        ext_trig_i = 1'b0;
    logic [15:0] sample_i = 16'h0;
    logic        trig_out_o;
    logic        hub_trig;
    logic [31:0] d;
    logic [15:0] v;
    logic [15:0] w [4];
    int          n_errors = 0;
    int          samples_checked = 0;
    lat_trigger_capture #(.DEPTH(DEPTH), .WIDTH(16)) dut_u (.mclk_i(mclk_i),
        .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .m0_i(m0_i), .m1_i(m1_i), .ext_trig_i(ext_trig_i),
        .sample_i(sample_i), .trig_out_o(trig_out_o));
    lat_hub_model hub_u (.trig_a_i(trig_out_o), .trig_b_i(1'b0), .hub_trig_o(hub_trig));
    initial forever #10 mclk_i = ~mclk_i;
    always @(posedge mclk_i) sample_i <= sample_i + 16'h1;
    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= dat;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic peek(input logic [31:0] idx);
        wr(`LAT_OFS_RDIDX, idx);
        rd(`LAT_OFS_RDDATA);
    endtask
    task automatic pulse(output logic [15:0] val);
        @(posedge mclk_i);
        m0_i <= 1'b1;
        #1 val = sample_i;
        @(posedge mclk_i);
        m0_i <= 1'b0;
    endtask
    task automatic wait_full();
        for (int i = 0; i < 300; i++) begin
            rd(`LAT_OFS_STATUS);
            if (d[2:0] === 3'h3) return;
        end
        n_errors++;
        end_of_test();
    endtask
    task automatic try(input logic [31:0] c, input logic [5:0] e, input logic [2:0] in,
                       input logic exp);
        wr(`LAT_OFS_CTRL, c);
        wr(`LAT_OFS_EQN, {26'h0, e});
        @(posedge mclk_i);
        {m0_i, m1_i, ext_trig_i} <= in;
        repeat (4) @(posedge mclk_i);
        #1 check("trig_out", {31'h0, trig_out_o}, {31'h0, exp});
        check("hub", {31'h0, hub_trig}, {31'h0, exp});
    endtask
    initial begin
        repeat (5) @(posedge mclk_i);
        reset_i <= 1'b0;
        rd(`LAT_OFS_CTRL);
        check("ctrl", d, 32'h0);
        rd(`LAT_OFS_STATUS);
        check("status", d, 32'h0);
        rd(8'h20);
        check("unmapped", d, 32'h0);
        try(32'h10, 6'h01, 3'b100, 1'b1);
        try(32'h10, 6'h05, 3'b100, 1'b0);
        try(32'h30, 6'h05, 3'b100, 1'b1);
        try(32'h30, 6'h12, 3'b100, 1'b0);
        try(32'h30, 6'h12, 3'b001, 1'b1);
        try(32'h30, 6'h00, 3'b111, 1'b0);
        try(32'h10, 6'h31, 3'b101, 1'b1);
        try(32'h00, 6'h04, 3'b010, 1'b0);
        wr(`LAT_OFS_EQN, 32'h05);
        try(32'h15, 6'h05, 3'b010, 1'b0);
        pulse(v);
        repeat (2) @(posedge mclk_i);
        #1 check("macro", {31'h0, trig_out_o}, 32'h1);
        wr(`LAT_OFS_CTRL, 32'h15);
        repeat (3) @(posedge mclk_i);
        #1 check("rearm", {31'h0, trig_out_o}, 32'h0);
        wr(`LAT_OFS_POS, 32'h5);
        try(32'h11, 6'h01, 3'b000, 1'b0);
        rd(`LAT_OFS_STATUS);
        check("armed", {29'h0, d[2:0]}, 32'h1);
        pulse(v);
        wait_full();
        check("count", {16'h0, d[31:16]}, 32'(DEPTH));
        peek(32'h0);
        check("idx0", d, {16'h0, v});
        peek(32'h3b);
        check("pre", d, {16'h0, v - 16'h5});
        peek(32'h3a);
        check("post", d, {16'h0, v + 16'h3a});
        pulse(w[0]);
        peek(32'h0);
        check("after_full", d, {16'h0, v});
        wr(`LAT_OFS_CTRL, 32'h02);
        rd(`LAT_OFS_STATUS);
        check("stopped", {29'h0, d[2:0]}, 32'h4);
        wr(`LAT_OFS_BURST, 32'hc);
        wr(`LAT_OFS_CTRL, 32'h19);
        for (int i = 0; i < 4; i++) begin
            pulse(w[i]);
            repeat (20) @(posedge mclk_i);
        end
        rd(`LAT_OFS_STATUS);
        check("bursts", {16'h0, d[31:16]}, 32'h34);
        pulse(v);
        wait_full();
        check("count2", {16'h0, d[31:16]}, 32'(DEPTH));
        peek(32'h0);
        check("first", d, {16'h0, w[0]});
        peek(32'hd);
        check("second", d, {16'h0, w[1]});
        peek(32'h3f);
        check("last", d, {16'h0, v + 16'hb});
        end_of_test();
    end
endmodule // lat_trigger_capture_test
